// >>> rtl/sepc_defines.svh
// Constants of the serial nonvolatile command and protect block.
`ifndef SEPC_DEFINES_SVH
`define SEPC_DEFINES_SVH

// Opcode keys are the opcode with its bit 3 removed.
`define SEPC_OP_LSET 7'h06
`define SEPC_OP_LCLR 7'h04
`define SEPC_OP_SRD 7'h05
`define SEPC_OP_SWR 7'h01
`define SEPC_OP_ARD 7'h03
`define SEPC_OP_AWR 7'h02

`define SEPC_ADDR_W 14
`define SEPC_MEM_DEPTH 16384
`define SEPC_COL_W 6
`define SEPC_PAGE_BYTES 64
`define SEPC_ADDR_LAST_BIT 5'h0F
`define SEPC_BYTE_LAST_BIT 5'h07

`define SEPC_SR_ARM 7
`define SEPC_SR_GHI 3
`define SEPC_SR_GLO 2
`define SEPC_SR_BUSY_VIEW 8'hFF
`define SEPC_ARM_RST 1'b0
`define SEPC_GUARD_RST 2'h0
`define SEPC_PINS_IDLE 4'h9

`define SEPC_G_NONE 2'h0
`define SEPC_G_QUART 2'h1
`define SEPC_G_HALF 2'h2
`define SEPC_G_ALL 2'h3

`define SEPC_CLK_PERIOD_NS 5
`define SEPC_TWC_MS 5
`define SEPC_TWC_CYCLES ((`SEPC_TWC_MS * 1000000) / `SEPC_CLK_PERIOD_NS)
`define SEPC_BUSY_CNT_W 20

`endif

// >>> rtl/sepc_pkg.sv
// Types of the serial nonvolatile command and protect block.
package sepc_pkg;

   typedef struct packed {
      logic cs_n;
      logic sck;
      logic si;
      logic protect_n;
   } sepc_pins_t;

   typedef enum logic [3:0] {
      st_idle = 4'h0,
      st_cmd = 4'h1,
      st_lset = 4'h2,
      st_lclr = 4'h3,
      st_srd = 4'h4,
      st_sdata = 4'h5,
      st_sfull = 4'h6,
      st_raddr = 4'h7,
      st_rdout = 4'h8,
      st_waddr = 4'h9,
      st_wdata = 4'hA,
      st_ignore = 4'hB
   } sepc_state_t;

   typedef struct packed {
      logic arm;
      logic [2:0] zero;
      logic [1:0] guard;
      logic wel;
      logic busy;
   } sepc_status_t;

endpackage

// >>> rtl/sepc_sync.sv
// Two-stage synchroniser for the serial pins.
`timescale 1ns/1ps
`include "sepc_defines.svh"
module sepc_sync
   import sepc_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input sepc_pins_t i_pins,
   output sepc_pins_t o_pins
);
   sepc_pins_t meta;

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         meta <= sepc_pins_t'(`SEPC_PINS_IDLE);
         o_pins <= sepc_pins_t'(`SEPC_PINS_IDLE);
      end
      else
      begin
         meta <= i_pins;
         o_pins <= meta;
      end
   end
endmodule // sepc_sync

// >>> rtl/sepc_top.sv
// Command decoder, write sequencer and protection of the serial memory.
`timescale 1ns/1ps
`include "sepc_defines.svh"
module sepc_top
   import sepc_pkg::*;
#(
   parameter int unsigned WRITE_CYCLES = `SEPC_TWC_CYCLES
)
(
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_cs_n,
   input wire logic i_sck,
   input wire logic i_si,
   input wire logic i_protect_n,
   output logic o_so,
   output logic o_so_oe,
   output logic o_busy
);
   localparam logic [`SEPC_BUSY_CNT_W-1:0] BUSY_LAST =
      `SEPC_BUSY_CNT_W'(WRITE_CYCLES - 1);
   localparam logic [`SEPC_COL_W-1:0] COL0 = `SEPC_COL_W'(0);

   sepc_pins_t pins_raw;
   sepc_pins_t pins_s;
   sepc_pins_t pins_d;
   sepc_state_t state;
   sepc_status_t status_view;
   logic [4:0] cnt;
   logic [6:0] shreg;
   logic [7:0] rx_byte;
   logic sck_rise;
   logic sck_fall;
   logic cs_rise;
   logic cs_fall;
   logic [14:0] addr_sh;
   logic [`SEPC_ADDR_W-1:0] rd_addr;
   logic [`SEPC_ADDR_W-`SEPC_COL_W-1:0] page;
   logic [`SEPC_COL_W-1:0] col;
   logic [7:0] page_buf [0:`SEPC_PAGE_BYTES-1];
   logic [`SEPC_PAGE_BYTES-1:0] byte_ok;
   logic got_byte;
   logic [7:0] sdata;
   logic wel;
   logic arm;
   logic [1:0] guard;
   logic busy;
   logic [`SEPC_BUSY_CNT_W-1:0] busy_cnt;
   logic pend_status;
   logic [2:0] out_cnt;
   logic [6:0] tx_sh;
   logic [7:0] mem [0:`SEPC_MEM_DEPTH-1];
   logic [7:0] next_byte;
   logic hw_prot;
   logic commit;
   logic start_status;
   logic start_array;
   logic wr_complete;

   // ****************************************************************
   // Decode helpers
   // ****************************************************************
   function automatic sepc_state_t decode(input logic [7:0] op,
                                          input logic busy_now);
      logic [6:0] key;
      key = {op[7:4], op[2:0]};
      decode = st_ignore;
      if (busy_now)
      begin
         if (key == `SEPC_OP_SRD)
            decode = st_srd;
      end
      else
      begin
         unique case (key)
            `SEPC_OP_LSET: decode = st_lset;
            `SEPC_OP_LCLR: decode = st_lclr;
            `SEPC_OP_SRD: decode = st_srd;
            `SEPC_OP_SWR: decode = st_sdata;
            `SEPC_OP_ARD: decode = st_raddr;
            `SEPC_OP_AWR: decode = st_waddr;
            default: decode = st_ignore;
         endcase
      end
   endfunction

   function automatic logic guarded(input logic [`SEPC_ADDR_W-1:0] a,
                                    input logic [1:0] g);
      unique case (g)
         `SEPC_G_NONE: guarded = 1'b0;
         `SEPC_G_QUART: guarded = &a[`SEPC_ADDR_W-1:`SEPC_ADDR_W-2];
         `SEPC_G_HALF: guarded = a[`SEPC_ADDR_W-1];
         `SEPC_G_ALL: guarded = 1'b1;
      endcase
   endfunction

   // ****************************************************************
   // Pin synchronisation and edge detection
   // ****************************************************************
   assign pins_raw = '{cs_n: i_cs_n, sck: i_sck, si: i_si,
                       protect_n: i_protect_n};

   sepc_sync u_sync (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_pins(pins_raw),
      .o_pins(pins_s)
   );

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
         pins_d <= sepc_pins_t'(`SEPC_PINS_IDLE);
      else
         pins_d <= pins_s;
   end

   // SI and SCK travel the same two stages, so the bit taken with a
   // rising SCK is the level that stood around that edge.
   assign sck_rise = pins_s.sck & ~pins_d.sck & ~pins_s.cs_n;
   assign sck_fall = ~pins_s.sck & pins_d.sck & ~pins_s.cs_n;
   assign cs_rise = pins_s.cs_n & ~pins_d.cs_n;
   assign cs_fall = ~pins_s.cs_n & pins_d.cs_n;
   assign rx_byte = {shreg, pins_s.si};
   assign hw_prot = arm & ~pins_s.protect_n;
   assign commit = busy && (busy_cnt == BUSY_LAST);
   assign wr_complete = (cnt == 5'h00) && got_byte;
   assign start_status = cs_rise && (state == st_sfull) && wel
                         && !hw_prot;
   // The guard boundaries fall on page boundaries, so one check on
   // the page base decides the whole page.
   assign start_array = cs_rise && (state == st_wdata) && wr_complete
                        && wel && !guarded({page, COL0}, guard);

   // ****************************************************************
   // Serial framing state
   // ****************************************************************
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         state <= st_idle;
         cnt <= 5'h00;
         shreg <= 7'h00;
      end
      else if (pins_s.cs_n)
      begin
         state <= st_idle;
         cnt <= 5'h00;
      end
      else if (cs_fall)
      begin
         state <= st_cmd;
         cnt <= 5'h00;
      end
      else if (sck_rise)
      begin
         shreg <= rx_byte[6:0];
         cnt <= cnt + 5'h01;
         unique case (state)
            st_cmd:
               if (cnt == `SEPC_BYTE_LAST_BIT)
               begin
                  state <= decode(rx_byte, busy);
                  cnt <= 5'h00;
               end
            st_lset, st_lclr, st_sfull:
               state <= st_ignore;
            st_sdata:
               if (cnt == `SEPC_BYTE_LAST_BIT)
               begin
                  state <= st_sfull;
                  cnt <= 5'h00;
               end
            st_raddr:
               if (cnt == `SEPC_ADDR_LAST_BIT)
               begin
                  state <= st_rdout;
                  cnt <= 5'h00;
               end
            st_waddr:
               if (cnt == `SEPC_ADDR_LAST_BIT)
               begin
                  state <= st_wdata;
                  cnt <= 5'h00;
               end
            st_wdata:
               if (cnt == `SEPC_BYTE_LAST_BIT)
                  cnt <= 5'h00;
            st_idle, st_srd, st_rdout, st_ignore:
               cnt <= 5'h00;
         endcase
      end
   end

   // ****************************************************************
   // Address capture and read pointer
   // ****************************************************************
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         addr_sh <= 15'h0000;
         rd_addr <= `SEPC_ADDR_W'(0);
         page <= '0;
      end
      else if (sck_rise && (state == st_raddr || state == st_waddr))
      begin
         addr_sh <= {addr_sh[13:0], pins_s.si};
         if (cnt == `SEPC_ADDR_LAST_BIT)
         begin
            rd_addr <= {addr_sh[12:0], pins_s.si};
            page <= addr_sh[12:5];
         end
      end
      else if (sck_fall && state == st_rdout && out_cnt == 3'h0)
         rd_addr <= rd_addr + `SEPC_ADDR_W'(1);
   end

   // ****************************************************************
   // Page buffer and status data capture
   // ****************************************************************
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         byte_ok <= '0;
         got_byte <= 1'b0;
         col <= COL0;
         sdata <= 8'h00;
      end
      else if (sck_rise)
      begin
         // A status read during a write cycle must not wipe the page that
         // is still waiting for the cycle to end.
         if (state == st_cmd && cnt == `SEPC_BYTE_LAST_BIT && !busy)
         begin
            byte_ok <= '0;
            got_byte <= 1'b0;
         end
         if (state == st_waddr && cnt == `SEPC_ADDR_LAST_BIT)
            col <= {addr_sh[4:0], pins_s.si};
         if (state == st_wdata && cnt == `SEPC_BYTE_LAST_BIT)
         begin
            page_buf[col] <= rx_byte;
            byte_ok[col] <= 1'b1;
            col <= col + `SEPC_COL_W'(1);
            got_byte <= 1'b1;
         end
         if (state == st_sdata && cnt == `SEPC_BYTE_LAST_BIT)
            sdata <= rx_byte;
      end
   end

   // ****************************************************************
   // Write latch, status bits and the self-timed cycle
   // ****************************************************************
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
         wel <= 1'b0;
      else if (cs_rise)
      begin
         if (state == st_lset)
            wel <= 1'b1;
         else if (state == st_lclr || state == st_sfull)
            wel <= 1'b0;
         else if (state == st_wdata && wr_complete)
            wel <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         arm <= `SEPC_ARM_RST;
         guard <= `SEPC_GUARD_RST;
      end
      else if (commit && pend_status)
      begin
         guard <= sdata[`SEPC_SR_GHI:`SEPC_SR_GLO];
         arm <= sdata[`SEPC_SR_ARM]
                | (arm & ~pins_s.protect_n);
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         busy <= 1'b0;
         busy_cnt <= '0;
         pend_status <= 1'b0;
      end
      else if (start_status || start_array)
      begin
         busy <= 1'b1;
         busy_cnt <= '0;
         pend_status <= start_status;
      end
      else if (commit)
         busy <= 1'b0;
      else if (busy)
         busy_cnt <= busy_cnt + `SEPC_BUSY_CNT_W'(1);
   end

   assign o_busy = busy;

   // The whole page lands in one clock; this costs one write port per
   // page column but keeps the cycle timer the only sequencer.
   always_ff @(posedge i_clk_sys)
   begin
      if (commit && !pend_status)
      begin
         for (int i = 0; i < `SEPC_PAGE_BYTES; i++)
         begin
            if (byte_ok[i] && !guarded({page, `SEPC_COL_W'(i)}, guard))
               mem[{page, `SEPC_COL_W'(i)}] <= page_buf[i];
         end
      end
   end

   // ****************************************************************
   // Serial output
   // ****************************************************************
   always_comb
   begin
      status_view = '{arm: arm, zero: 3'h0, guard: guard, wel: wel,
                      busy: 1'b0};
      if (busy)
         status_view = sepc_status_t'(`SEPC_SR_BUSY_VIEW);
      next_byte = (state == st_srd) ? status_view : mem[rd_addr];
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n || pins_s.cs_n)
      begin
         o_so <= 1'b0;
         o_so_oe <= 1'b0;
         out_cnt <= 3'h0;
         tx_sh <= 7'h00;
      end
      else if (sck_fall && (state == st_srd || state == st_rdout))
      begin
         o_so_oe <= 1'b1;
         out_cnt <= out_cnt + 3'h1;
         if (out_cnt == 3'h0)
         begin
            o_so <= next_byte[7];
            tx_sh <= next_byte[6:0];
         end
         else
         begin
            o_so <= tx_sh[6];
            tx_sh <= {tx_sh[5:0], 1'b0};
         end
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);

   property p_hiz_ignore;
      state == st_ignore |-> !o_so_oe;
   endproperty
   a_hiz_ignore: assert property (p_hiz_ignore)
      else $error("Serial output driven after unknown opcode.");

   property p_wel_clear;
      cs_rise && (state == st_lclr || state == st_sfull) |=> !wel;
   endproperty
   a_wel_clear: assert property (p_wel_clear)
      else $error("Write latch not cleared.");

   property p_wel_set;
      $rose(wel) |-> $past(cs_rise) && $past(state) == st_lset;
   endproperty
   a_wel_set: assert property (p_wel_set)
      else $error("Write latch set without latch set opcode.");

   property p_busy_only_srd;
      sck_rise && state == st_cmd && cnt == 5'h07 && busy
         && rx_byte[2:0] != 3'h5 |=> state == st_ignore;
   endproperty
   a_busy_only_srd: assert property (p_busy_only_srd)
      else $error("Opcode accepted while busy.");

   property p_srd_busy_ones;
      busy && state == st_srd && sck_fall && out_cnt == 3'h0
         |=> o_so && o_so_oe;
   endproperty
   a_srd_busy_ones: assert property (p_srd_busy_ones)
      else $error("Busy status bit not one.");

   property p_status_hold;
      busy && !commit |=> $stable(arm) && $stable(guard);
   endproperty
   a_status_hold: assert property (p_status_hold)
      else $error("Status changed before cycle end.");

   property p_sw_reject;
      cs_rise && state == st_sfull && (!wel || hw_prot) |=> !busy;
   endproperty
   a_sw_reject: assert property (p_sw_reject)
      else $error("Protected status write started a cycle.");

   property p_arm_keep;
      commit && pend_status && arm && !pins_s.protect_n |=> arm;
   endproperty
   a_arm_keep: assert property (p_arm_keep)
      else $error("Arm bit cleared with protect pin low.");

   property p_cycle_len;
      $fell(busy) |-> $past(busy_cnt) == BUSY_LAST;
   endproperty
   a_cycle_len: assert property (p_cycle_len)
      else $error("Write cycle length wrong.");

   property p_guard_block;
      cs_rise && state == st_wdata && guarded({page, COL0}, guard)
         |=> !busy;
   endproperty
   a_guard_block: assert property (p_guard_block)
      else $error("Guarded page write started a cycle.");

   property p_rd_wrap;
      sck_fall && state == st_rdout && out_cnt == 3'h0 && (&rd_addr)
         |=> rd_addr == `SEPC_ADDR_W'(0);
   endproperty
   a_rd_wrap: assert property (p_rd_wrap)
      else $error("Read address did not wrap.");

endmodule // sepc_top

// >>> verif/sepc_master.sv
// Bus master model driving the serial pins of the memory block.
`timescale 1ns/1ps
module sepc_master
(
   input wire logic i_clk,
   input wire logic i_so,
   input wire logic i_so_oe,
   output logic o_cs_n,
   output logic o_sck,
   output logic o_si
);
   // ****************
   // Pin driving
   // ****************
   localparam int HALF = 16;
   logic oe_seen = 1'h0;
   initial
   begin
      o_cs_n = 1'h1;
      o_sck = 1'h0;
      o_si = 1'h1;
   end
   always @(posedge i_clk)
   begin
      if (o_cs_n)
         oe_seen <= 1'h0;
      else if (i_so_oe)
         oe_seen <= 1'h1;
   end
   task automatic pause(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   task automatic open_frame();
      pause(1);
      o_cs_n = 1'h0;
      pause(8);
   endtask
   // Mode 0: SI moves while SCK is low, SO is taken just before it rises.
   task automatic shift(input logic [7:0] tx, input int n,
                        output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i >= 8 - n; i--)
      begin
         o_si = tx[i];
         pause(HALF);
         rx[i] = i_so_oe ? i_so : 1'hx;
         o_sck = 1'h1;
         pause(HALF);
         o_sck = 1'h0;
      end
   endtask
   // A released SI shows the inverse of its last bit, never a stale value.
   task automatic close_frame();
      pause(HALF);
      o_cs_n = 1'h1;
      o_si = ~o_si;
      pause(10);
   endtask
endmodule // sepc_master

// >>> verif/test_spi_eeprom_command_protect.sv
// Self-checking bench of the serial memory command and protect block.
`timescale 1ns/1ps
module test_spi_eeprom_command_protect;
   // ****************
   // Set-up
   // ****************
   localparam int WC = 1200;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic prot_n = 1'h1;
   logic cs_n, sck, si, so, so_oe, busy;
   logic [7:0] rx;
   logic [7:0] mem [int];
   int n_fail = 0;
   int compares = 0;
   int cyc = 0;
   int bcnt = 0;
   int blen = 0;
   int nbusy = 0;
   sepc_top #(.WRITE_CYCLES(WC)) dut (
      .i_clk_sys(clk),
      .i_rst_n(rst_n),
      .i_cs_n(cs_n),
      .i_sck(sck),
      .i_si(si),
      .i_protect_n(prot_n),
      .o_so(so),
      .o_so_oe(so_oe),
      .o_busy(busy)
   );
   sepc_master m (
      .i_clk(clk),
      .i_so(so),
      .i_so_oe(so_oe),
      .o_cs_n(cs_n),
      .o_sck(sck),
      .o_si(si)
   );
   initial
   begin
      forever #2.5 clk = ~clk;
   end
   // Busy runs are measured apart from the frame traffic.
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (busy === 1'h1)
         bcnt <= bcnt + 1;
      else if (bcnt != 0)
      begin
         blen <= bcnt;
         nbusy <= nbusy + 1;
         bcnt <= 0;
      end
   end
   always @(negedge clk)
   begin
      if (cyc == 95000)
      begin
         n_fail = n_fail + 1;
         wrap_up();
      end
   end
   // ****************
   // Tasks
   // ****************
   task automatic wrap_up();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] exp,
                        input logic [15:0] got);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic guarded(input logic [1:0] g, input int a);
      return g == 2'h3 || (g == 2'h2 && a >= 32'h2000) ||
             (g == 2'h1 && a >= 32'h3000);
   endfunction
   task automatic cmd(input logic [7:0] op);
      m.open_frame();
      m.shift(op, 8, rx);
      m.close_frame();
   endtask
   task automatic unknown(input logic [7:0] op);
      m.open_frame();
      m.shift(op, 8, rx);
      m.shift(8'hFF, 8, rx);
      check("output enable", 16'h0, 16'(m.oe_seen));
      m.close_frame();
   endtask
   task automatic rd_status(input logic [7:0] exp, input int n);
      m.open_frame();
      m.shift(8'h05, 8, rx);
      repeat (n)
      begin
         m.shift(8'h00, 8, rx);
         check("status", 16'(exp), 16'(rx));
      end
      m.close_frame();
   endtask
   task automatic settle(input logic ok);
      int n0;
      n0 = nbusy;
      repeat (WC + 30) @(negedge clk);
      check("write cycles", 16'(ok), 16'(nbusy - n0));
      if (ok)
         check("busy length", 16'(WC), 16'(blen));
   endtask
   task automatic sw_frame(input logic [7:0] dat);
      m.open_frame();
      m.shift(8'h01, 8, rx);
      m.shift(dat, 8, rx);
      m.close_frame();
   endtask
   task automatic wr_status(input logic [7:0] dat, input logic ok);
      sw_frame(dat);
      settle(ok);
   endtask
   task automatic wr_array(input logic [15:0] a, input int n,
                           input int tail, input logic ok);
      logic [7:0] b;
      m.open_frame();
      m.shift(8'h02, 8, rx);
      m.shift(a[15:8], 8, rx);
      m.shift(a[7:0], 8, rx);
      for (int i = 0; i < n; i++)
      begin
         b = 8'($urandom);
         m.shift(b, 8, rx);
         if (ok)
            mem[{a[13:6], 6'(a[5:0] + i)}] = b;
      end
      if (tail > 0)
         m.shift(8'hA5, tail, rx);
      m.close_frame();
      // A status poll in mid-cycle must leave the pending page intact.
      if (ok)
         rd_status(8'hFF, 1);
      settle(ok);
   endtask
   task automatic rd_array(input logic [15:0] a, input int n);
      int k;
      m.open_frame();
      m.shift(8'h03, 8, rx);
      m.shift(a[15:8], 8, rx);
      m.shift(a[7:0], 8, rx);
      for (int i = 0; i < n; i++)
      begin
         k = (int'(a) + i) % 16384;
         m.shift(8'h00, 8, rx);
         if (mem.exists(k))
            check("array byte", 16'(mem[k]), 16'(rx));
      end
      m.close_frame();
   endtask
   // ****************
   // Scenarios
   // ****************
   initial
   begin
      void'($urandom(32'h1bc8));
      repeat (4) @(negedge clk);
      rst_n = 1'h1;
      repeat (6) @(negedge clk);
      rd_status(8'h00, 2);
      cmd(8'h0E);
      rd_status(8'h02, 1);
      for (int i = 0; i < 4; i++)
         unknown(8'h07 + 8'(i) * 8'h0F);
      rd_status(8'h02, 1);
      cmd(8'h04);
      rd_status(8'h00, 1);
      wr_status(8'hFC, 1'h0);
      rd_status(8'h00, 1);
      cmd(8'h06);
      sw_frame(8'hF4);
      rd_status(8'hFF, 1);
      cmd(8'h06);
      settle(1'h1);
      rd_status(8'h84, 1);
      prot_n = 1'h0;
      cmd(8'h06);
      wr_status(8'h00, 1'h0);
      rd_status(8'h84, 1);
      // The pin drops while the clearing write is already running, so
      // the arm bit has to survive the commit while the guard bits move.
      prot_n = 1'h1;
      cmd(8'h06);
      sw_frame(8'h00);
      prot_n = 1'h0;
      settle(1'h1);
      rd_status(8'h80, 1);
      cmd(8'h06);
      wr_array(16'h0000, 2, 0, 1'h1);
      prot_n = 1'h1;
      cmd(8'h06);
      wr_status(8'h00, 1'h1);
      rd_status(8'h00, 1);
      for (int g = 1; g < 4; g++)
      begin
         cmd(8'h06);
         wr_status(8'(g << 2), 1'h1);
         for (int j = 0; j < 3; j++)
         begin
            cmd(8'h06);
            wr_array(16'h1FFF + 16'(j) * 16'h1000, 1, 0,
                     !guarded(2'(g), 32'h1FFF + j * 32'h1000));
         end
      end
      cmd(8'h06);
      wr_status(8'h00, 1'h1);
      cmd(8'h06);
      wr_array(16'hFFFE, 66, 0, 1'h1);
      cmd(8'h06);
      wr_array(16'h0000, 1, 4, 1'h0);
      rd_status(8'h02, 1);
      cmd(8'h04);
      wr_array(16'h0001, 1, 0, 1'h0);
      rd_array(16'hFFFC, 6);
      rd_array(16'h3FC0, 4);
      wrap_up();
   end
endmodule // test_spi_eeprom_command_protect
